//--- ffss_consts.vh
`ifndef FFSS_CONSTS_VH
`define FFSS_CONSTS_VH
// Register addresses
`define FFSS_ADDR_W 16
`define FFSS_ADDR_CHAN_A 16'hFE3E
`define FFSS_ADDR_CHAN_B 16'hFE3F
// Field positions
`define FFSS_BIT_DB_TIME 5
`define FFSS_BIT_DB_EN 4
`define FFSS_BIT_FF_SEL 3
`define FFSS_BIT_FF_EN 2
`define FFSS_GAIN_HI 1
`define FFSS_GAIN_LO 0
// Reset value: feedforward source select at one, all else zero
`define FFSS_CFG_RST 8'h08
// Debounce intervals of 5 ms and 10 ms counted in 100 MHz clock cycles
`define FFSS_DB_SHORT_CYC 20'h7A120
`define FFSS_DB_LONG_CYC 20'hF4240
`define FFSS_CNT_W 20
// Soft-start filter gain values
`define FFSS_GAIN_X1 4'h1
`define FFSS_GAIN_X2 4'h2
`define FFSS_GAIN_X4 4'h4
`define FFSS_GAIN_X8 4'h8
`endif

//--- ffss_sync.v
`timescale 1ns/1ps
`default_nettype none
module ffss_sync (
   input wire clk,
   input wire rst_n,
   input wire d,
   output wire q
);
   reg s1_q;
   reg s2_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
      end
   end
   assign q = s2_q;
endmodule // ffss_sync
`default_nettype wire

//--- ffss_debounce.v
`timescale 1ns/1ps
`include "ffss_consts.vh"
`default_nettype none
module ffss_debounce #(
   parameter [`FFSS_CNT_W-1:0] SHORT_CYC = `FFSS_DB_SHORT_CYC,
   parameter [`FFSS_CNT_W-1:0] LONG_CYC = `FFSS_DB_LONG_CYC
) (
   input wire clk,
   input wire rst_n,
   input wire enable,
   input wire long_sel,
   input wire settled,
   input wire ss_active,
   output wire done
);
   reg [`FFSS_CNT_W-1:0] cnt_q;
   reg [`FFSS_CNT_W-1:0] cnt_d;
   reg done_q;
   reg done_d;
   wire [`FFSS_CNT_W-1:0] limit;
   assign limit = long_sel ? LONG_CYC : SHORT_CYC;
   always @* begin
      cnt_d = cnt_q;
      done_d = done_q;
      if (!ss_active) begin
         cnt_d = {`FFSS_CNT_W{1'b0}};
         done_d = 1'b0;
      end else if (!enable) begin
         cnt_d = {`FFSS_CNT_W{1'b0}};
         done_d = settled;
      end else if (!settled) begin
         // Any unsettled sample restarts the interval
         cnt_d = {`FFSS_CNT_W{1'b0}};
         done_d = 1'b0;
      end else if (cnt_q >= limit - 1'b1) begin
         done_d = 1'b1;
      end else begin
         cnt_d = cnt_q + 1'b1;
      end
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= {`FFSS_CNT_W{1'b0}};
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         done_q <= done_d;
      end
   end
   assign done = done_q;
endmodule // ffss_debounce
`default_nettype wire

//--- ffss_cfg.v
`timescale 1ns/1ps
`include "ffss_consts.vh"
`default_nettype none
module ffss_cfg #(
   parameter [`FFSS_CNT_W-1:0] SHORT_CYC = `FFSS_DB_SHORT_CYC,
   parameter [`FFSS_CNT_W-1:0] LONG_CYC = `FFSS_DB_LONG_CYC
) (
   input wire REF_CLK,
   input wire NRST,
   input wire [`FFSS_ADDR_W-1:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [7:0] RDATA,
   input wire CHAN_A_VOLT_SENSE_SETTLED,
   input wire CHAN_B_VOLT_SENSE_SETTLED,
   input wire CHAN_A_SS_ACTIVE,
   input wire CHAN_B_SS_ACTIVE,
   output reg CHAN_A_SS_DONE,
   output reg CHAN_B_SS_DONE,
   output reg CHAN_A_FF_EN,
   output reg CHAN_B_FF_EN,
   output reg CHAN_A_FF_SRC_INPUT_VOLT_SENSE_ADC,
   output reg CHAN_B_FF_SRC_INPUT_VOLT_SENSE_ADC,
   output reg [3:0] CHAN_A_SS_GAIN,
   output reg [3:0] CHAN_B_SS_GAIN
);
   reg [7:0] cfg_q [0:1];
   wire [1:0] settled_raw;
   wire [1:0] ss_raw;
   wire [1:0] settled_s;
   wire [1:0] ss_s;
   wire [1:0] db_done;
   reg [7:0] rdata_d;

   // Next values of the output flip-flops
   reg [3:0] gain_a_d;
   reg [3:0] gain_b_d;
   reg ss_done_a_d;
   reg ss_done_b_d;
   reg ff_en_a_d;
   reg ff_en_b_d;
   reg ff_src_a_d;
   reg ff_src_b_d;

   // Field views of both registers
   wire [1:0] ff_en_v;
   wire [1:0] ff_src_v;
   wire [3:0] gain_sel;

   assign settled_raw = {CHAN_B_VOLT_SENSE_SETTLED, CHAN_A_VOLT_SENSE_SETTLED};
   assign ss_raw = {CHAN_B_SS_ACTIVE, CHAN_A_SS_ACTIVE};

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
         wire hit;
         wire db_en;
         wire db_long;

         // Debounce controls of this channel
         assign db_en = cfg_q[ch][`FFSS_BIT_DB_EN];
         assign db_long = cfg_q[ch][`FFSS_BIT_DB_TIME];
         assign hit = (ADDR == (ch == 0 ? `FFSS_ADDR_CHAN_A : `FFSS_ADDR_CHAN_B));
         // Whole byte stored, reserved bits included
         always @(posedge REF_CLK or negedge NRST) begin
            if (!NRST) begin
               cfg_q[ch] <= `FFSS_CFG_RST;
            end else if (WR && hit) begin
               cfg_q[ch] <= WDATA;
            end
         end
         ffss_sync u_sync_settled (
            .clk(REF_CLK),
            .rst_n(NRST),
            .d(settled_raw[ch]),
            .q(settled_s[ch])
         );
         ffss_sync u_sync_ss (
            .clk(REF_CLK),
            .rst_n(NRST),
            .d(ss_raw[ch]),
            .q(ss_s[ch])
         );
         // Each channel watches only its own sense converter
         ffss_debounce #(
            .SHORT_CYC(SHORT_CYC),
            .LONG_CYC(LONG_CYC)
         ) u_db (
            .clk(REF_CLK),
            .rst_n(NRST),
            .enable(db_en),
            .long_sel(db_long),
            .settled(settled_s[ch]),
            .ss_active(ss_s[ch]),
            .done(db_done[ch])
         );
      end
   endgenerate

   // Feedforward and gain fields of both channels
   assign ff_en_v = {cfg_q[1][`FFSS_BIT_FF_EN], cfg_q[0][`FFSS_BIT_FF_EN]};

   assign ff_src_v = {cfg_q[1][`FFSS_BIT_FF_SEL], cfg_q[0][`FFSS_BIT_FF_SEL]};

   assign gain_sel = {cfg_q[1][`FFSS_GAIN_HI:`FFSS_GAIN_LO], cfg_q[0][`FFSS_GAIN_HI:`FFSS_GAIN_LO]};

   // Soft-start filter gain decode
   // Channel A: unity gain outside soft start
   always @* begin
      gain_a_d = `FFSS_GAIN_X1;
      if (ss_s[0]) begin
         case (gain_sel[1:0])
            2'h0: begin
               gain_a_d = `FFSS_GAIN_X1;
            end
            2'h1: begin
               gain_a_d = `FFSS_GAIN_X2;
            end
            2'h2: begin
               gain_a_d = `FFSS_GAIN_X4;
            end
            2'h3: begin
               gain_a_d = `FFSS_GAIN_X8;
            end
            default: begin
               gain_a_d = `FFSS_GAIN_X1;
            end
         endcase
      end else begin
         gain_a_d = `FFSS_GAIN_X1;
      end
   end

   // Channel B: unity gain outside soft start
   always @* begin
      gain_b_d = `FFSS_GAIN_X1;
      if (ss_s[1]) begin
         case (gain_sel[3:2])
            2'h0: begin
               gain_b_d = `FFSS_GAIN_X1;
            end
            2'h1: begin
               gain_b_d = `FFSS_GAIN_X2;
            end
            2'h2: begin
               gain_b_d = `FFSS_GAIN_X4;
            end
            2'h3: begin
               gain_b_d = `FFSS_GAIN_X8;
            end
            default: begin
               gain_b_d = `FFSS_GAIN_X1;
            end
         endcase
      end else begin
         gain_b_d = `FFSS_GAIN_X1;
      end
   end

   // Read data follow the address of the read cycle; unmapped reads give zero
   always @* begin
      rdata_d = 8'h00;
      if (RD) begin
         case (ADDR)
            `FFSS_ADDR_CHAN_A: begin
               rdata_d = cfg_q[0];
            end
            `FFSS_ADDR_CHAN_B: begin
               rdata_d = cfg_q[1];
            end
            default: begin
               rdata_d = 8'h00;
            end
         endcase
      end else begin
         rdata_d = 8'h00;
      end
   end

   // Next values
   // Soft start done, channel A
   always @* begin
      ss_done_a_d = db_done[0];
   end

   // Soft start done, channel B
   always @* begin
      ss_done_b_d = db_done[1];
   end

   // Feedforward enable, channel A
   always @* begin
      ff_en_a_d = ff_en_v[0];
   end

   // Feedforward enable, channel B
   always @* begin
      ff_en_b_d = ff_en_v[1];
   end

   // Feedforward source, channel A
   always @* begin
      ff_src_a_d = ff_src_v[0];
   end

   // Feedforward source, channel B
   always @* begin
      ff_src_b_d = ff_src_v[1];
   end

   // Registered outputs: every port comes straight from its own flip-flop

   // Read data stand in the cycle after each read cycle; zero after a cycle with RD low
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         RDATA <= 8'h00;
      end else begin
         RDATA <= rdata_d;
      end
   end

   // Channel A done
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         CHAN_A_SS_DONE <= 1'b0;
      end else begin
         CHAN_A_SS_DONE <= ss_done_a_d;
      end
   end

   // Channel B done
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         CHAN_B_SS_DONE <= 1'b0;
      end else begin
         CHAN_B_SS_DONE <= ss_done_b_d;
      end
   end

   // Channel A feedforward enable
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         CHAN_A_FF_EN <= 1'b0;
      end else begin
         CHAN_A_FF_EN <= ff_en_a_d;
      end
   end

   // Channel B feedforward enable
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         CHAN_B_FF_EN <= 1'b0;
      end else begin
         CHAN_B_FF_EN <= ff_en_b_d;
      end
   end

   // Channel A feedforward source
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         CHAN_A_FF_SRC_INPUT_VOLT_SENSE_ADC <= 1'b1;
      end else begin
         CHAN_A_FF_SRC_INPUT_VOLT_SENSE_ADC <= ff_src_a_d;
      end
   end

   // Channel B feedforward source
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         CHAN_B_FF_SRC_INPUT_VOLT_SENSE_ADC <= 1'b1;
      end else begin
         CHAN_B_FF_SRC_INPUT_VOLT_SENSE_ADC <= ff_src_b_d;
      end
   end

   // Channel A filter gain
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         CHAN_A_SS_GAIN <= `FFSS_GAIN_X1;
      end else begin
         CHAN_A_SS_GAIN <= gain_a_d;
      end
   end

   // Channel B filter gain
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         CHAN_B_SS_GAIN <= `FFSS_GAIN_X1;
      end else begin
         CHAN_B_SS_GAIN <= gain_b_d;
      end
   end
endmodule // ffss_cfg
`default_nettype wire

//--- ffss_cfg_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ffss_chk #(parameter [19:0] SHORT_CYC = 20'hA, parameter [19:0] LONG_CYC = 20'h14) (
   input wire REF_CLK,
   input wire NRST,
   input wire [15:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   input wire [7:0] RDATA,
   input wire CHAN_A_VOLT_SENSE_SETTLED,
   input wire CHAN_A_SS_ACTIVE,
   input wire CHAN_A_SS_DONE,
   input wire CHAN_A_FF_EN,
   input wire [3:0] CHAN_A_SS_GAIN,
   input wire CHAN_A_FF_SRC_INPUT_VOLT_SENSE_ADC,
   input wire CHAN_B_FF_EN
);
   reg [7:0] a_q;
   reg [7:0] b_q;
   reg [19:0] n_q;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   // Shadows of the channel A and B registers and run length of channel A settled soft start
   always @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         a_q <= 8'h08;
         b_q <= 8'h08;
         n_q <= 20'h0;
      end else begin
         a_q <= (WR && ADDR == 16'hFE3E) ? WDATA : a_q;
         b_q <= (WR && ADDR == 16'hFE3F) ? WDATA : b_q;
         n_q <= (CHAN_A_VOLT_SENSE_SETTLED && CHAN_A_SS_ACTIVE) ? n_q + 20'h1 : 20'h0;
      end
   end
   property p_ff; $stable(a_q)[*3] |-> CHAN_A_FF_EN == a_q[2]; endproperty
   a_ff: assert property (p_ff) else $error("ff enable");
   property p_rd; (RD && ADDR == 16'hFE3E) |=> RDATA == a_q; endproperty
   a_rd: assert property (p_rd) else $error("readback");
   property p_db; $rose(CHAN_A_SS_DONE) && a_q[4] |-> n_q >= (a_q[5] ? LONG_CYC : SHORT_CYC); endproperty
   a_db: assert property (p_db) else $error("debounce short");
   property p_gain_idle; (!CHAN_A_SS_ACTIVE)[*4] |-> CHAN_A_SS_GAIN == 4'h1; endproperty
   a_gain_idle: assert property (p_gain_idle) else $error("gain outside soft start");
   property p_gain_on; (CHAN_A_SS_ACTIVE && $stable(a_q))[*4] |-> CHAN_A_SS_GAIN == (4'h1 << a_q[1:0]); endproperty
   a_gain_on: assert property (p_gain_on) else $error("gain in soft start");
   property p_src; $stable(a_q)[*3] |-> CHAN_A_FF_SRC_INPUT_VOLT_SENSE_ADC == a_q[3]; endproperty
   a_src: assert property (p_src) else $error("ff source");
   property p_b_ff; $stable(b_q)[*3] |-> CHAN_B_FF_EN == b_q[2]; endproperty
   a_b_ff: assert property (p_b_ff) else $error("chan b ff enable");
endmodule // ffss_chk
bind ffss_cfg ffss_chk #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) chk_u (.*);
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   reg clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, sa = 1'b0, aa = 1'b0, sb = 1'b0, ab = 1'b1;
   reg [15:0] ad = 16'h0;
   reg [7:0] wd = 8'h0;
   reg [7:0] cfg [0:2] = '{8'h08, 8'h18, 8'h38};
   wire [7:0] q;
   wire da, db, fa, fb;
   wire [3:0] ga, gb;
   integer bad_count = 0, n_tests = 0, cyc = 0, i, n;
   ffss_cfg #(.SHORT_CYC(20'hA), .LONG_CYC(20'h14)) dut_u (.REF_CLK(clk), .NRST(nrst), .ADDR(ad), .WDATA(wd),
      .WR(wr), .RD(rd), .RDATA(q), .CHAN_A_VOLT_SENSE_SETTLED(sa), .CHAN_B_VOLT_SENSE_SETTLED(sb),
      .CHAN_A_SS_ACTIVE(aa), .CHAN_B_SS_ACTIVE(ab), .CHAN_A_SS_DONE(da), .CHAN_B_SS_DONE(db), .CHAN_A_FF_EN(fa),
      .CHAN_B_FF_EN(fb), .CHAN_A_FF_SRC_INPUT_VOLT_SENSE_ADC(), .CHAN_B_FF_SRC_INPUT_VOLT_SENSE_ADC(),
      .CHAN_A_SS_GAIN(ga), .CHAN_B_SS_GAIN(gb));
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         summarize;
      end
   end
   task chk(input string nm, input [7:0] s, input [7:0] e);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %s exp %h seen %h", nm, e, s);
      end
   endtask
   // One bus cycle; a read compares the data of the following cycle
   task acc(input w, input [15:0] a, input [7:0] d);
      @(posedge clk);
      ad <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      if (!w) chk("rdata", q, d);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      acc(0, 16'hFE3E, 8'h08);
      acc(0, 16'hFE40, 8'h00);
      acc(1, 16'hFE3F, 8'hC3);
      @(posedge clk);
      aa <= 1'b1;
      for (i = 0; i < 4; i++) begin
         acc(1, 16'hFE3E, 8'hC4 | i[7:0]);
         repeat (8) @(posedge clk);
         acc(0, 16'hFE3E, 8'hC4 | i[7:0]);
         chk("gain", {ga, gb}, 8'h08 | (8'h10 << i));
         chk("ffen", {fa, fb}, 8'h02);
      end
      for (i = 0; i < 3; i++) begin
         acc(1, 16'hFE3E, cfg[i]);
         @(posedge clk);
         aa <= 1'b1;
         sa <= 1'b1;
         n = 0;
         while (da !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
         end
         chk("delay", {db, (n >= 10 * i && n <= 10 * i + 8)}, 8'h01);
         @(posedge clk);
         aa <= 1'b0;
         sa <= 1'b0;
         repeat (6) @(negedge clk);
         chk("idle", {da, ga}, 8'h01);
      end
      @(posedge clk);
      sb <= 1'b1;
      repeat (6) @(negedge clk);
      chk("chan b", {db, da}, 8'h02);
      summarize;
   end
endmodule // testbench
`default_nettype wire
